// ===== rtl/srch_pkg.sv
// Constants shared by both ends of the stream read command handler.
// Assumes one 250 MHz clock and a byte-wide command block bus.
package srch_pkg;
   // ==========================================================
   // Command block register addresses and command code
   localparam logic [2:0] A_DATA = 3'h0;
   localparam logic [2:0] A_FEAT = 3'h1;
   localparam logic [2:0] A_CNT  = 3'h2;
   localparam logic [2:0] A_SN   = 3'h3;
   localparam logic [2:0] A_CLO  = 3'h4;
   localparam logic [2:0] A_CHI  = 3'h5;
   localparam logic [2:0] A_DH   = 3'h6;
   localparam logic [2:0] A_CMD  = 3'h7;
   localparam logic [7:0] CMD_READ_STREAM = 8'h2B;
   // ==========================================================
   // Feature byte fields
   localparam int F_URG = 7;
   localparam int F_RC  = 6;
   localparam int F_NS  = 5;
   localparam int F_HSE = 4;
   localparam int F_SID = 0;
   localparam int SID_W = 3;
   // ==========================================================
   // Error and status bits
   localparam int E_COMPLETION_TIMEOUT_FLAG = 0;
   localparam int E_ABT  = 2;
   localparam int E_IDN  = 4;
   localparam int E_UNC  = 6;
   localparam int E_CRC  = 7;
   localparam int S_BSY  = 7;
   localparam int S_RDY  = 6;
   localparam int S_SE   = 5;
   localparam int S_DRQ  = 3;
   localparam int S_ERR  = 0;
   localparam logic [7:0] ERR_RESET = 8'h00;
   // ==========================================================
   // Timing and sizes
   localparam int CLK_PERIOD_NS = 4;
   localparam int US_NS         = 1000;
   localparam logic [7:0] CYC_PER_US = 8'((US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [15:0] COMPLETION_TIME_LIMIT_UNIT_US = 16'h0001;
   localparam logic [23:0] COMPLETION_TIME_LIMIT_MIN_US  = 24'h00_0010;
   localparam logic [16:0] MAX_SECTORS  = 17'h1_0000;
   localparam int STREAMS = 8;
   localparam int N_RD    = 10;
endpackage

// ===== rtl/srch_if.sv
// Link between the host end and the device end of the handler.
// Assumes both ends share clk and reset.
`timescale 1ns/10ps
interface srch_if (
   input wire logic clk,
   input wire logic reset
);
   logic        wr_en;
   logic        rd_en;
   logic [2:0]  addr;
   logic        high_order_selector;
   logic [7:0]  wdata;
   logic [7:0]  rdata;
   logic        rvalid;
   logic        intrq;
   logic        sec_valid;
   logic        sec_ready;
   logic [47:0] sec_lba;
   logic        sec_bad;

   modport dev (input clk, reset, wr_en, rd_en, addr, high_order_selector, wdata, sec_ready,
                output rdata, rvalid, intrq, sec_valid, sec_lba, sec_bad);
   modport host (input clk, reset, rdata, rvalid, intrq, sec_valid, sec_lba, sec_bad,
                 output wr_en, rd_en, addr, high_order_selector, wdata, sec_ready);
endinterface

// ===== rtl/srch_device.sv
// Device end of the stream read command handler.
// Assumes a media engine that reads one sector per request.
`timescale 1ns/10ps
module srch_device
   import srch_pkg::*;
(
   srch_if.dev                 link,
   output logic                med_req,
   output logic [47:0]         med_lba,
   output logic                med_urgent,
   output logic                med_not_seq,
   output logic                med_resume,
   output logic [SID_W-1:0]    med_stream,
   input  wire logic           med_ack,
   input  wire logic [7:0]     med_err,
   input  wire logic           cfg_we,
   input  wire logic [SID_W-1:0] cfg_stream,
   input  wire logic [23:0]    cfg_limit_us,
   output logic                log_we,
   output logic [7:0]          log_bits
);
   import srch_pkg::*;

   typedef enum {ST_IDLE, ST_MEDIA, ST_XFER} srch_state_t;

   // ==========================================================
   // State
   srch_state_t  st_reg, st_next;
   logic [7:0]   cur_reg [8];
   logic [7:0]   cur_next [8];
   logic [7:0]   prv_reg [8];
   logic [7:0]   prv_next [8];
   logic [23:0]  dflt_reg [STREAMS];
   logic [47:0]  lba_reg, lba_next, first_reg, first_next;
   logic [16:0]  left_reg, left_next;
   logic [15:0]  run_reg, run_next;
   logic         inrun_reg, inrun_next;
   logic [7:0]   feat_reg, feat_next;
   logic [23:0]  lim_reg, lim_next, us_reg, us_next;
   logic         limen_reg, limen_next;
   logic [7:0]   pre_reg, pre_next;
   logic [7:0]   err_reg, err_next, log_reg, log_next;
   logic         se_reg, se_next, errf_reg, errf_next, bad_reg, bad_next;
   logic         intrq_reg, intrq_next, logwe_reg, logwe_next;
   logic [7:0]   rd_reg, rd_next;
   logic         rv_reg, rv_next;
   logic [23:0]  raw_us;
   logic [16:0]  req_cnt;
   logic         start, timeout, finish;

   function automatic logic [7:0] pick(input logic [7:0] lo, input logic [7:0] hi,
                                       input logic sel);
      pick = sel ? hi : lo;
   endfunction

   // ==========================================================
   // Per-stream default limits
   for (genvar g = 0; g < STREAMS; g++) begin : g_dflt
      always_ff @(posedge link.clk) begin
         if (link.reset) begin
            dflt_reg[g] <= 24'h00_0000;
         end else if (cfg_we && cfg_stream == SID_W'(g)) begin
            dflt_reg[g] <= cfg_limit_us;
         end
      end
   end

   // ==========================================================
   // Next state
   always_comb begin
      st_next    = st_reg;
      cur_next   = cur_reg;
      prv_next   = prv_reg;
      lba_next   = lba_reg;
      first_next = first_reg;
      left_next  = left_reg;
      run_next   = run_reg;
      inrun_next = inrun_reg;
      feat_next  = feat_reg;
      lim_next   = lim_reg;
      limen_next = limen_reg;
      us_next    = us_reg;
      pre_next   = pre_reg;
      err_next   = err_reg;
      log_next   = log_reg;
      se_next    = se_reg;
      errf_next  = errf_reg;
      bad_next   = bad_reg;
      intrq_next = 1'b0;
      logwe_next = 1'b0;
      finish     = 1'b0;
      start = link.wr_en && st_reg == ST_IDLE && link.addr == A_CMD
              && link.wdata == CMD_READ_STREAM;
      req_cnt = {1'b0, prv_reg[A_CNT], cur_reg[A_CNT]};
      if (req_cnt == 17'h0_0000) begin
         req_cnt = MAX_SECTORS;
      end
      if (prv_reg[A_FEAT] != 8'h00) begin
         raw_us = 24'(prv_reg[A_FEAT] * COMPLETION_TIME_LIMIT_UNIT_US);
      end else begin
         raw_us = dflt_reg[cur_reg[A_FEAT][F_SID +: SID_W]];
      end
      timeout = limen_reg && us_reg >= lim_reg && st_reg != ST_IDLE;
      if (link.wr_en && st_reg == ST_IDLE && link.addr != A_CMD) begin
         prv_next[link.addr] = cur_reg[link.addr];
         cur_next[link.addr] = link.wdata;
      end
      if (pre_reg == CYC_PER_US - 8'h01) begin
         pre_next = 8'h00;
         us_next  = us_reg + 24'h00_0001;
      end else begin
         pre_next = pre_reg + 8'h01;
      end
      case (st_reg)
         ST_IDLE: begin
            if (start) begin
               st_next    = ST_MEDIA;
               feat_next  = cur_reg[A_FEAT];
               lba_next   = {prv_reg[A_CHI], prv_reg[A_CLO], prv_reg[A_SN],
                             cur_reg[A_CHI], cur_reg[A_CLO], cur_reg[A_SN]};
               first_next = 48'h0000_0000_0000;
               left_next  = req_cnt;
               run_next   = 16'h0000;
               inrun_next = 1'b0;
               limen_next = raw_us != 24'h00_0000;
               lim_next   = (raw_us < COMPLETION_TIME_LIMIT_MIN_US) ? COMPLETION_TIME_LIMIT_MIN_US : raw_us;
               us_next    = 24'h00_0000;
               pre_next   = 8'h00;
               err_next   = ERR_RESET;
               log_next   = ERR_RESET;
               se_next    = 1'b0;
               errf_next  = 1'b0;
            end
         end
         ST_MEDIA: begin
            if (timeout) begin
               finish = 1'b1;
            end else if (med_ack) begin
               bad_next = med_err != 8'h00;
               if (med_err != 8'h00 && feat_reg[F_RC]) begin
                  log_next = log_reg | med_err;
                  if (!se_reg) begin
                     first_next = lba_reg;
                     run_next   = 16'h0001;
                     inrun_next = 1'b1;
                  end else if (inrun_reg) begin
                     run_next = run_reg + 16'h0001;
                  end
                  se_next = 1'b1;
                  st_next = ST_XFER;
               end else if (med_err != 8'h00) begin
                  err_next   = med_err;
                  errf_next  = 1'b1;
                  first_next = lba_reg;
                  finish     = 1'b1;
               end else begin
                  inrun_next = 1'b0;
                  st_next    = ST_XFER;
               end
            end
         end
         ST_XFER: begin
            if (timeout) begin
               finish = 1'b1;
            end else if (link.sec_ready) begin
               lba_next  = lba_reg + 48'h0000_0000_0001;
               left_next = left_reg - 17'h0_0001;
               if (left_reg == 17'h0_0001) begin
                  finish = 1'b1;
               end else begin
                  st_next = ST_MEDIA;
               end
            end
         end
         default: st_next = ST_IDLE;
      endcase
      if (timeout) begin
         err_next[E_COMPLETION_TIMEOUT_FLAG] = 1'b1;
         if (feat_reg[F_RC]) begin
            se_next  = 1'b1;
            log_next = log_next | (8'h01 << E_COMPLETION_TIMEOUT_FLAG);
         end else begin
            errf_next = 1'b1;
         end
      end
      if (finish) begin
         st_next    = ST_IDLE;
         intrq_next = 1'b1;
         logwe_next = feat_reg[F_RC] && se_next;
         if (feat_reg[F_RC] && se_next) begin
            err_next  = err_next & (8'h01 << E_COMPLETION_TIMEOUT_FLAG);
            errf_next = 1'b0;
         end
      end
      case ({link.high_order_selector, link.addr})
         {1'b0, A_FEAT}, {1'b1, A_FEAT}: rd_next = err_reg;
         {1'b0, A_CMD}, {1'b1, A_CMD}: begin
            rd_next = 8'h00;
            rd_next[S_BSY] = st_reg != ST_IDLE;
            rd_next[S_RDY] = 1'b1;
            rd_next[S_SE]  = se_reg;
            rd_next[S_DRQ] = st_reg == ST_XFER;
            rd_next[S_ERR] = errf_reg;
         end
         {1'b0, A_CNT}, {1'b1, A_CNT}: rd_next = pick(run_reg[7:0], run_reg[15:8], link.high_order_selector);
         {1'b0, A_SN}, {1'b1, A_SN}: rd_next = pick(first_reg[7:0], first_reg[31:24], link.high_order_selector);
         {1'b0, A_CLO}, {1'b1, A_CLO}: rd_next = pick(first_reg[15:8], first_reg[39:32],
                                                      link.high_order_selector);
         {1'b0, A_CHI}, {1'b1, A_CHI}: rd_next = pick(first_reg[23:16], first_reg[47:40],
                                                      link.high_order_selector);
         default: rd_next = pick(cur_reg[link.addr], prv_reg[link.addr], link.high_order_selector);
      endcase
      rv_next = link.rd_en;
   end

   // ==========================================================
   // Registers
   always_ff @(posedge link.clk) begin
      if (link.reset) begin
         st_reg    <= ST_IDLE;
         for (int i = 0; i < 8; i++) begin
            cur_reg[i] <= 8'h00;
            prv_reg[i] <= 8'h00;
         end
         lba_reg   <= 48'h0000_0000_0000;
         first_reg <= 48'h0000_0000_0000;
         left_reg  <= 17'h0_0000;
         run_reg   <= 16'h0000;
         inrun_reg <= 1'b0;
         feat_reg  <= 8'h00;
         lim_reg   <= 24'h00_0000;
         limen_reg <= 1'b0;
         us_reg    <= 24'h00_0000;
         pre_reg   <= 8'h00;
         err_reg   <= ERR_RESET;
         log_reg   <= ERR_RESET;
         se_reg    <= 1'b0;
         errf_reg  <= 1'b0;
         bad_reg   <= 1'b0;
         intrq_reg <= 1'b0;
         logwe_reg <= 1'b0;
         rd_reg    <= 8'h00;
         rv_reg    <= 1'b0;
      end else begin
         st_reg    <= st_next;
         cur_reg   <= cur_next;
         prv_reg   <= prv_next;
         lba_reg   <= lba_next;
         first_reg <= first_next;
         left_reg  <= left_next;
         run_reg   <= run_next;
         inrun_reg <= inrun_next;
         feat_reg  <= feat_next;
         lim_reg   <= lim_next;
         limen_reg <= limen_next;
         us_reg    <= us_next;
         pre_reg   <= pre_next;
         err_reg   <= err_next;
         log_reg   <= log_next;
         se_reg    <= se_next;
         errf_reg  <= errf_next;
         bad_reg   <= bad_next;
         intrq_reg <= intrq_next;
         logwe_reg <= logwe_next;
         rd_reg    <= rd_next;
         rv_reg    <= rv_next;
      end
   end

   // ==========================================================
   // Outputs
   assign med_req        = st_reg == ST_MEDIA && !timeout;
   assign med_lba        = lba_reg;
   assign med_urgent     = feat_reg[F_URG];
   assign med_not_seq    = feat_reg[F_NS];
   assign med_resume     = feat_reg[F_HSE];
   assign med_stream     = feat_reg[F_SID +: SID_W];
   assign log_we         = logwe_reg;
   assign log_bits       = log_reg;
   assign link.rdata     = rd_reg;
   assign link.rvalid    = rv_reg;
   assign link.intrq     = intrq_reg;
   assign link.sec_valid = st_reg == ST_XFER && !timeout;
   assign link.sec_lba   = lba_reg;
   assign link.sec_bad   = bad_reg;
endmodule

// ===== rtl/srch_host.sv
// Host end of the stream read command handler.
// Assumes the user holds command fields stable while busy is high.
`timescale 1ns/10ps
module srch_host
   import srch_pkg::*;
(
   srch_if.host         link,
   input  wire logic        start,
   input  wire logic [47:0] lba,
   input  wire logic [15:0] count,
   input  wire logic [7:0]  feat,
   input  wire logic [7:0]  completion_time_limit,
   output logic             busy,
   output logic             done,
   output logic [7:0]       res_status,
   output logic [7:0]       res_error,
   output logic [47:0]      res_lba,
   output logic [15:0]      res_count,
   output logic             got_valid,
   input  wire logic        got_ready,
   output logic [47:0]      got_lba,
   output logic             got_bad
);
   import srch_pkg::*;

   typedef enum {HS_IDLE, HS_WR, HS_WAIT, HS_RD, HS_RDW} srch_hstate_t;

   srch_hstate_t st_reg, st_next;
   logic [3:0]   idx_reg, idx_next;
   logic [7:0]   res_reg [N_RD];
   logic [7:0]   res_next [N_RD];
   logic         done_reg, done_next;
   logic [10:0]  wstep;
   logic [3:0]   rstep;

   // Write order: high (previous) byte before low (current) byte.
   function automatic logic [10:0] wr_step(input logic [3:0] i);
      case (i)
         4'h0: wr_step = {A_FEAT, completion_time_limit};
         4'h1: wr_step = {A_FEAT, feat};
         4'h2: wr_step = {A_CNT, count[15:8]};
         4'h3: wr_step = {A_CNT, count[7:0]};
         4'h4: wr_step = {A_SN, lba[31:24]};
         4'h5: wr_step = {A_SN, lba[7:0]};
         4'h6: wr_step = {A_CLO, lba[39:32]};
         4'h7: wr_step = {A_CLO, lba[15:8]};
         4'h8: wr_step = {A_CHI, lba[47:40]};
         4'h9: wr_step = {A_CHI, lba[23:16]};
         default: wr_step = {A_CMD, CMD_READ_STREAM};
      endcase
   endfunction

   // Read order: status, error, then each pair with selector low then high.
   function automatic logic [3:0] rd_step(input logic [3:0] i);
      case (i)
         4'h0: rd_step = {1'b0, A_CMD};
         4'h1: rd_step = {1'b0, A_FEAT};
         4'h2: rd_step = {1'b0, A_CNT};
         4'h3: rd_step = {1'b1, A_CNT};
         4'h4: rd_step = {1'b0, A_SN};
         4'h5: rd_step = {1'b1, A_SN};
         4'h6: rd_step = {1'b0, A_CLO};
         4'h7: rd_step = {1'b1, A_CLO};
         4'h8: rd_step = {1'b0, A_CHI};
         default: rd_step = {1'b1, A_CHI};
      endcase
   endfunction

   // ==========================================================
   // Next state
   always_comb begin
      st_next   = st_reg;
      idx_next  = idx_reg;
      res_next  = res_reg;
      done_next = 1'b0;
      case (st_reg)
         HS_IDLE: begin
            if (start) begin
               st_next  = HS_WR;
               idx_next = 4'h0;
            end
         end
         HS_WR: begin
            idx_next = idx_reg + 4'h1;
            if (idx_reg == 4'hA) begin
               st_next = HS_WAIT;
            end
         end
         HS_WAIT: begin
            if (link.intrq) begin
               st_next  = HS_RD;
               idx_next = 4'h0;
            end
         end
         HS_RD: st_next = HS_RDW;
         HS_RDW: begin
            if (link.rvalid) begin
               res_next[idx_reg] = link.rdata;
               idx_next = idx_reg + 4'h1;
               if (idx_reg == 4'(N_RD - 1)) begin
                  st_next   = HS_IDLE;
                  done_next = 1'b1;
               end else begin
                  st_next = HS_RD;
               end
            end
         end
         default: st_next = HS_IDLE;
      endcase
   end

   // ==========================================================
   // Registers
   always_ff @(posedge link.clk) begin
      if (link.reset) begin
         st_reg   <= HS_IDLE;
         idx_reg  <= 4'h0;
         done_reg <= 1'b0;
         for (int i = 0; i < N_RD; i++) begin
            res_reg[i] <= 8'h00;
         end
      end else begin
         st_reg   <= st_next;
         idx_reg  <= idx_next;
         done_reg <= done_next;
         res_reg  <= res_next;
      end
   end

   // ==========================================================
   // Outputs
   assign link.wr_en     = st_reg == HS_WR;
   assign link.rd_en     = st_reg == HS_RD;
   assign wstep          = wr_step(idx_reg);
   assign rstep          = rd_step(idx_reg);
   assign link.addr      = (st_reg == HS_WR) ? wstep[10:8] : rstep[2:0];
   assign link.high_order_selector       = (st_reg == HS_WR) ? 1'b0 : rstep[3];
   assign link.wdata     = wstep[7:0];
   assign link.sec_ready = got_ready;
   assign got_valid      = link.sec_valid;
   assign got_lba        = link.sec_lba;
   assign got_bad        = link.sec_bad;
   assign busy           = st_reg != HS_IDLE;
   assign done           = done_reg;
   assign res_status     = res_reg[0];
   assign res_error      = res_reg[1];
   assign res_count      = {res_reg[3], res_reg[2]};
   assign res_lba        = {res_reg[9], res_reg[7], res_reg[5],
                            res_reg[8], res_reg[6], res_reg[4]};
endmodule

// ===== sim/srch_properties.sv
// Concurrent checks on the link between the host and device ends.
// Assumes instantiation in tb beside the interface, on one clock.
`timescale 1ns/10ps
module srch_properties
   import srch_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        wr_en,
   input wire logic        rd_en,
   input wire logic [2:0]  addr,
   input wire logic        high_order_selector,
   input wire logic [7:0]  wdata,
   input wire logic [7:0]  rdata,
   input wire logic        rvalid,
   input wire logic        intrq,
   input wire logic        sec_valid,
   input wire logic        sec_ready,
   input wire logic [47:0] sec_lba,
   input wire logic        sec_bad
);
   // ==========================================================
   // Command tracking
   logic act_reg;
   logic act_next;
   logic rc_reg;
   logic rc_next;
   always_comb begin
      act_next = act_reg;
      rc_next  = rc_reg;
      if (wr_en && !act_reg && addr == A_FEAT) rc_next = wdata[F_RC];
      if (wr_en && !act_reg && addr == A_CMD && wdata == CMD_READ_STREAM) act_next = 1'b1;
      if (intrq) act_next = 1'b0;
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         act_reg <= 1'b0;
         rc_reg  <= 1'b0;
      end else begin
         act_reg <= act_next;
         rc_reg  <= rc_next;
      end
   end
   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   chk_read_answer: assert property (rd_en |=> rvalid)
      else $error("read not answered");
   chk_answer_cause: assert property (rvalid |-> $past(rd_en))
      else $error("answer without read");
   chk_done_needs_cmd: assert property (intrq |-> act_reg)
      else $error("completion without command");
   chk_end_not_busy: assert property (rd_en && addr == A_CMD && !act_reg |=> !rdata[S_BSY])
      else $error("busy after completion");
   chk_offer_in_cmd: assert property (sec_valid |-> act_reg)
      else $error("sector outside command");
   chk_offer_held: assert property (sec_valid && !sec_ready |=> sec_valid && $stable(sec_lba))
      else $error("sector offer dropped");
   chk_bad_needs_rc: assert property (sec_valid && sec_bad |-> rc_reg)
      else $error("bad sector in normal mode");
   chk_irq_pulse: assert property (intrq |=> !intrq)
      else $error("completion pulse too long");
   chk_se_not_err: assert property (rd_en && addr == A_CMD && !act_reg |=> !(rdata[S_SE] && rdata[S_ERR]))
      else $error("stream error with error status");
   chk_err_to_log: assert property (rd_en && addr == A_FEAT && !high_order_selector && !act_reg && rc_reg |=> rdata[7:1] == 7'h00)
      else $error("error bits left in error register");
   cov_done: cover property (intrq);
   cov_bad: cover property (sec_valid && sec_bad);
   cov_stall: cover property (sec_valid && !sec_ready);
endmodule

// ===== sim/tb.sv
// Testbench joining the host and device ends of the stream read handler.
// Assumes the files under rtl/ are compiled first.
`timescale 1ns/10ps
module tb;
   import srch_pkg::*;
   logic        clk, reset, start, got_ready, med_ack, cfg_we, busy, done;
   logic        got_valid, got_bad, log_we, med_req, med_urgent, med_not_seq, med_resume;
   logic [47:0] lba, res_lba, got_lba, med_lba, exp_lba;
   logic [15:0] count, res_count;
   logic [7:0]  feat, completion_time_limit, res_status, res_error, med_err, log_bits, log_seen;
   logic [2:0]  med_stream, cfg_stream;
   logic [23:0] cfg_limit_us;
   int          errors, tests_run, nrx, dly, bad_at, nsec, cyc;
   srch_if link (.clk(clk), .reset(reset));
   srch_device u_srch_device (.link(link), .med_req(med_req), .med_lba(med_lba),
      .med_urgent(med_urgent), .med_not_seq(med_not_seq), .med_resume(med_resume),
      .med_stream(med_stream), .med_ack(med_ack), .med_err(med_err), .cfg_we(cfg_we),
      .cfg_stream(cfg_stream), .cfg_limit_us(cfg_limit_us), .log_we(log_we),
      .log_bits(log_bits));
   srch_host u_srch_host (.link(link), .start(start), .lba(lba), .count(count), .feat(feat),
      .completion_time_limit(completion_time_limit), .busy(busy), .done(done), .res_status(res_status), .res_error(res_error),
      .res_lba(res_lba), .res_count(res_count), .got_valid(got_valid), .got_ready(got_ready),
      .got_lba(got_lba), .got_bad(got_bad));
   srch_properties u_srch_properties (.clk(link.clk), .reset(link.reset), .wr_en(link.wr_en),
      .rd_en(link.rd_en), .addr(link.addr), .high_order_selector(link.high_order_selector), .wdata(link.wdata),
      .rdata(link.rdata), .rvalid(link.rvalid), .intrq(link.intrq),
      .sec_valid(link.sec_valid), .sec_ready(link.sec_ready), .sec_lba(link.sec_lba),
      .sec_bad(link.sec_bad));
   // ==========================================================
   // Clock, sector sink and media engine
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(negedge clk) got_ready <= ~got_ready;
   always @(posedge clk) begin
      if (got_valid === 1'b1 && got_ready === 1'b1) begin
         chk("got_lba", exp_lba, got_lba);
         exp_lba = exp_lba + 48'h0000_0000_0001;
         nrx++;
      end
      if (log_we === 1'b1) log_seen = log_bits;
   end
   initial begin
      med_ack = 1'b0;
      med_err = 8'h00;
      forever begin
         @(negedge clk);
         med_ack = 1'b0;
         if (med_req === 1'b1) begin
            for (int k = 0; k < dly && med_req === 1'b1; k++) @(negedge clk);
            if (med_req === 1'b1) begin
               med_ack = 1'b1;
               med_err = (nsec == bad_at) ? 8'h40 : 8'h00;
               nsec++;
            end
         end
      end
   end
   // ==========================================================
   // Tasks
   task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic run(input logic [47:0] l, input logic [15:0] c, input logic [7:0] f,
                      input logic [7:0] t, input int d, input int b);
      int n;
      lba = l;
      count = c;
      feat = f;
      completion_time_limit = t;
      dly = d;
      bad_at = b;
      exp_lba = l;
      nrx = 0;
      nsec = 0;
      log_seen = 8'h00;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      for (n = 1; n < 30000 && done !== 1'b1; n++) @(negedge clk);
      cyc = n;
   endtask
   task automatic conclude;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #200000;
      errors++;
      conclude();
   end
   // ==========================================================
   // Scenarios
   initial begin
      reset = 1'b1;
      start = 1'b0;
      got_ready = 1'b0;
      cfg_we = 1'b0;
      cfg_stream = 3'h0;
      cfg_limit_us = 24'h00_0000;
      lba = 48'h0;
      count = 16'h0000;
      feat = 8'h00;
      completion_time_limit = 8'h00;
      dly = 1;
      bad_at = -1;
      errors = 0;
      tests_run = 0;
      repeat (2) @(negedge clk);
      reset = 1'b0;
      run(48'h1234_5678_9ABC, 16'h0102, 8'h05, 8'h00, 1, -1);
      chk("sectors", 48'h0000_0000_0102, nrx);
      chk("status", 8'h00, res_status & 8'hA1);
      chk("stream", 3'h5, med_stream);
      chk("err_lba", 48'h0, res_lba);
      run(48'h0000_0000_1000, 16'h0002, 8'hF2, 8'h00, 1, 0);
      chk("sectors", 48'h0000_0000_0002, nrx);
      chk("status", 8'h20, res_status & 8'hA1);
      chk("err_lba", 48'h0000_0000_1000, res_lba);
      chk("run_len", 16'h0001, res_count);
      chk("error", 8'h00, res_error & 8'hFE);
      chk("log_unc", 1'b1, log_seen[E_UNC]);
      chk("flags", 6'h3A, {med_urgent, med_not_seq, med_resume, med_stream});
      run(48'h0000_0000_2000, 16'h0003, 8'h00, 8'h00, 1, 1);
      chk("sectors", 48'h0000_0000_0001, nrx);
      chk("status", 8'h01, res_status & 8'hA1);
      chk("error", 8'h40, res_error);
      chk("err_lba", 48'h0000_0000_2001, res_lba);
      run(48'h0000_0000_3000, 16'h0004, 8'h41, 8'h01, 6000, -1);
      chk("elapsed", 1'b1, cyc >= 4000 && cyc <= 4100);
      chk("status", 8'h20, res_status & 8'hA1);
      chk("completion_timeout_flag", 1'b1, res_error[E_COMPLETION_TIMEOUT_FLAG]);
      chk("log_completion_timeout_flag", 1'b1, log_seen[E_COMPLETION_TIMEOUT_FLAG]);
      @(negedge clk);
      cfg_we = 1'b1;
      cfg_stream = 3'h3;
      cfg_limit_us = 24'h00_0014;
      @(negedge clk);
      cfg_we = 1'b0;
      run(48'h0000_0000_4000, 16'h0001, 8'h03, 8'h00, 7000, -1);
      chk("elapsed", 1'b1, cyc >= 5000 && cyc <= 5100);
      chk("status", 8'h01, res_status & 8'hA1);
      chk("completion_timeout_flag", 1'b1, res_error[E_COMPLETION_TIMEOUT_FLAG]);
      conclude();
   end
endmodule
